// *** hdl/nbd_alu.sv ***
// Four-bit arithmetic and logic unit with decimal adjust
`timescale 1ns/10ps
module nbd_alu (
    input wire logic [2:0] op,
    input wire logic [3:0] a,
    input wire logic [3:0] b,
    input wire logic carry_in,
    input wire logic decimal,
    output logic [3:0] result,
    output logic carry_out
);
    logic [4:0] raw;
    always_comb
    begin
        raw = 5'h00;
        result = 4'h0;
        carry_out = carry_in;
        case (op)
            nbd_pkg::ALU_ADD, nbd_pkg::ALU_ADD_PLUS_CARRY:
            begin
                raw = {1'b0, a} + {1'b0, b} + {4'h0, carry_in & op[1]};
                result = raw[3:0];
                carry_out = raw[4];
                // Decimal mode keeps the nibble within 0..9
                if (decimal && raw > nbd_pkg::BCD_MAX)
                begin
                    result = raw[3:0] + nbd_pkg::BCD_ADJ;
                    carry_out = 1'b1;
                end
            end
            nbd_pkg::ALU_SUB, nbd_pkg::ALU_SUBTRACT_MINUS_CARRY:
            begin
                raw = {1'b0, a} - {1'b0, b} - {4'h0, carry_in & op[1]};
                result = raw[3:0];
                carry_out = raw[4];
                if (decimal && raw[4])
                begin
                    result = raw[3:0] - nbd_pkg::BCD_ADJ;
                end
            end
            nbd_pkg::ALU_AND: result = a & b;
            nbd_pkg::ALU_XOR: result = a ^ b;
            nbd_pkg::ALU_OR: result = a | b;
            default: result = a;
        endcase
    end
endmodule : nbd_alu

// *** hdl/nbd_core.sv ***
// Instruction decode and execute core of the nibble controller
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module nbd_core #(
    parameter int PC_W = nbd_pkg::PC_W
) (
    input wire logic ref_clk,
    input wire logic rstn,
    output logic [PC_W-1:0] imem_addr,
    input wire logic [15:0] imem_data,
    input wire logic [2:0] port_b_in,
    output logic [2:0] port_b_out,
    output logic [2:0] port_b_oe,
    input wire logic [3:0] port_c_in,
    output logic [3:0] port_c_out,
    output logic [3:0] port_c_oe,
    input wire logic [3:0] port_d_in,
    output logic [3:0] port_d_out,
    output logic [3:0] port_d_oe,
    output logic standby,
    output logic osc_stopped
);
    logic [1:0] rst_pipe;
    logic rst_n;
    nbd_pkg::nbd_state_t state;
    logic [3:0] wait_cnt;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] return_address_stack;
    logic [0:0] stack_pointer;
    logic skip_next;
    logic [3:0] wake_cond;
    logic [3:0] ram [16];
    logic [2:0] latch_b;
    logic [3:0] latch_c;
    logic [3:0] latch_d;
    logic dir_b, dir_c, dir_d;
    logic decimal_flag, zero_flag, carry_flag, compare_flag;
    logic next_zero, next_carry, next_compare;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            rst_pipe <= 2'h0;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_n = rst_pipe[1];

    ////////////////////////////////////////////////////////////////////////////
    // Field decode
    nbd_pkg::nbd_instr_t ins;
    assign ins = nbd_pkg::nbd_instr_t'(imem_data);
    wire [4:0] op = ins.opcode;
    wire [6:0] maddr = {ins.row_field, ins.column_field};
    wire [6:0] raddr = {nbd_pkg::ROW_RAM, ins.immediate_nibble};
    wire [3:0] imm = ins.immediate_nibble;
    wire [PC_W-1:0] target = PC_W'(imem_data[nbd_pkg::PC_W-1:0]);

    // memory-mapped read, port B bit 3 fixed zero
    function automatic logic [3:0] rd_mem(input logic [6:0] a);
        logic [3:0] v;
        v = 4'h0;
        if (a[6:4] == nbd_pkg::ROW_RAM)
            v = ram[a[3:0]];
        else if (a == nbd_pkg::A_PORT_B)
            v = {1'b0, dir_b ? latch_b : port_b_in};
        else if (a == nbd_pkg::A_PORT_C)
            v = dir_c ? latch_c : port_c_in;
        else if (a == nbd_pkg::A_PORT_D)
            v = dir_d ? latch_d : port_d_in;
        else if (a == nbd_pkg::A_BCD)
            v = {3'h0, decimal_flag};
        else if (a == nbd_pkg::A_PSW)
            v = {compare_flag, carry_flag, zero_flag, 1'b0};
        return v;
    endfunction : rd_mem

    wire [3:0] mval = rd_mem(maddr);
    wire [3:0] rval = rd_mem(raddr);

    wire exec = (state == nbd_pkg::ST_RUN) && !skip_next;
    wire is_alu = (op[3] == 1'b0) && (op[2:0] != nbd_pkg::ALU_NONE);
    wire is_cmp = (op == nbd_pkg::OP_SKE) || (op == nbd_pkg::OP_SKIP_IF_NOT_EQUAL)
        || (op == nbd_pkg::OP_SKIP_IF_NO_BORROW) || (op == nbd_pkg::OP_SKIP_IF_BORROW);
    wire is_arith = is_alu && !op[2];
    wire is_rotate_right_via_carry = imem_data[15:4] == nbd_pkg::W_ROTATE_RIGHT_VIA_CARRY;
    wire is_ret = (imem_data == nbd_pkg::W_RET) || (imem_data == nbd_pkg::W_RETURN_THEN_SKIP);
    wire is_stop = imem_data[15:4] == nbd_pkg::W_STOP;
    wire is_halt = imem_data[15:4] == nbd_pkg::W_HALT;
    wire is_call = op == nbd_pkg::OP_CALL;
    wire is_jump = (op == nbd_pkg::OP_JMP) || is_call;
    wire stop_ok = is_stop && !port_b_in[nbd_pkg::PB_WAKE];

    ////////////////////////////////////////////////////////////////////////////
    // ALU: memory-destination forms use the immediate
    wire [2:0] alu_op = is_alu ? op[2:0] : nbd_pkg::ALU_SUB;
    wire [3:0] alu_a = (op[4] || is_cmp) ? mval : rval;
    wire [3:0] alu_b = (op[4] || is_cmp) ? imm : mval;
    wire [3:0] alu_res;
    wire alu_cy;

    nbd_alu u_alu (
        .op(alu_op),
        .a(alu_a),
        .b(alu_b),
        .carry_in(carry_flag),
        .decimal(decimal_flag && is_alu),
        .result(alu_res),
        .carry_out(alu_cy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write-back selection
    wire wr_mem = (is_alu && op[4]) || op == nbd_pkg::OP_ST || op == nbd_pkg::OP_MOV;
    wire wr_reg = (is_alu && !op[4]) || op == nbd_pkg::OP_LD || is_rotate_right_via_carry;
    wire mem_we = exec && (wr_mem || wr_reg);
    wire [6:0] waddr = wr_mem ? maddr : raddr;
    wire [3:0] wdata = is_alu ? alu_res
        : (op == nbd_pkg::OP_LD) ? mval
        : (op == nbd_pkg::OP_ST) ? rval
        : is_rotate_right_via_carry ? {carry_flag, rval[3:1]} : imm;

    wire skt_hit = (mval & imm) == imm;
    wire skf_hit = (mval & imm) == 4'h0;
    wire cmp_skip = (op == nbd_pkg::OP_SKE && alu_res == 4'h0)
        || (op == nbd_pkg::OP_SKIP_IF_NOT_EQUAL && alu_res != 4'h0)
        || (op == nbd_pkg::OP_SKIP_IF_NO_BORROW && !alu_cy)
        || (op == nbd_pkg::OP_SKIP_IF_BORROW && alu_cy);
    wire next_skip = exec && ((op == nbd_pkg::OP_SKT && skt_hit)
        || (op == nbd_pkg::OP_SKF && skf_hit) || cmp_skip
        || imem_data == nbd_pkg::W_RETURN_THEN_SKIP);

    wire wake_halt = |(wake_cond & {1'b0, port_b_in});
    wire wake_stop = port_b_in[nbd_pkg::PB_WAKE];
    wire stop_init = (state == nbd_pkg::ST_STOP) && wake_stop
        && wake_cond == nbd_pkg::STOP_INIT;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= nbd_pkg::ST_WAIT;
            wait_cnt <= 4'h0;
            pc <= '0;
            skip_next <= 1'b0;
            wake_cond <= 4'h0;
            stack_pointer <= nbd_pkg::SP_EMPTY;
            return_address_stack <= '0;
        end
        else
        begin
            case (state)
                nbd_pkg::ST_WAIT:
                begin
                    wait_cnt <= wait_cnt + 4'h1;
                    if (wait_cnt == 4'(nbd_pkg::SETTLE_CLKS - 1))
                        state <= nbd_pkg::ST_RUN;
                end
                nbd_pkg::ST_RUN:
                begin
                    skip_next <= next_skip;
                    pc <= pc + 1'b1;
                    if (exec && is_jump)
                        pc <= target;
                    if (exec && is_call)
                    begin
                        return_address_stack <= pc + 1'b1;
                        stack_pointer <= stack_pointer - 1'b1;
                    end
                    if (exec && is_ret)
                    begin
                        pc <= return_address_stack;
                        stack_pointer <= stack_pointer + 1'b1;
                    end
                    // stop ignored with wake pin high
                    if (exec && (stop_ok || is_halt))
                    begin
                        wake_cond <= imm;
                        state <= stop_ok ? nbd_pkg::ST_STOP : nbd_pkg::ST_HALT;
                    end
                end
                nbd_pkg::ST_HALT:
                    if (wake_halt)
                        state <= nbd_pkg::ST_RUN;
                nbd_pkg::ST_STOP:
                    if (wake_stop)
                    begin
                        state <= nbd_pkg::ST_WAIT;
                        wait_cnt <= 4'h0;
                        if (stop_init)
                            pc <= '0;
                    end
                default: state <= nbd_pkg::ST_WAIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags; a direct write to the status word wins over computed flags
    always_comb
    begin
        next_zero = zero_flag;
        next_carry = carry_flag;
        next_compare = compare_flag;
        if (exec && is_arith)
            next_carry = alu_cy;
        if (exec && is_alu)
            next_zero = alu_res == 4'h0;
        if (exec && is_rotate_right_via_carry)
            next_carry = rval[0];
        if (exec && (op == nbd_pkg::OP_SKT || op == nbd_pkg::OP_SKF))
            next_compare = 1'b0;
        if (mem_we && waddr == nbd_pkg::A_PSW)
        begin
            next_zero = wdata[nbd_pkg::PSW_Z];
            next_carry = wdata[nbd_pkg::PSW_CY];
            next_compare = wdata[nbd_pkg::PSW_CMP];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {zero_flag, carry_flag, compare_flag, decimal_flag} <= 4'h0;
            {dir_b, dir_c, dir_d} <= 3'h0;
            latch_b <= 3'h0;
            latch_c <= 4'h0;
            latch_d <= 4'h0;
        end
        else if (stop_init)
        begin
            {zero_flag, carry_flag, compare_flag} <= 3'h0;
            {dir_b, dir_c, dir_d} <= 3'h0;
        end
        else
        begin
            zero_flag <= next_zero;
            carry_flag <= next_carry;
            compare_flag <= next_compare;
            // Writing a port latch turns that port to output
            if (mem_we && waddr == nbd_pkg::A_PORT_B)
                {dir_b, latch_b} <= {1'b1, wdata[2:0]};
            if (mem_we && waddr == nbd_pkg::A_PORT_C)
                {dir_c, latch_c} <= {1'b1, wdata};
            if (mem_we && waddr == nbd_pkg::A_PORT_D)
                {dir_d, latch_d} <= {1'b1, wdata};
            if (mem_we && waddr == nbd_pkg::A_BCD)
                decimal_flag <= wdata[nbd_pkg::BCD_BIT];
        end
    end

    // Data memory keeps its contents through reset
    always_ff @(posedge ref_clk)
    begin
        if (mem_we && waddr[6:4] == nbd_pkg::ROW_RAM)
            ram[waddr[3:0]] <= wdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins: port B is open drain, it only pulls low
    assign imem_addr = pc;
    assign port_b_out = 3'h0;
    assign port_b_oe = {3{dir_b}} & ~latch_b;
    assign port_c_out = latch_c;
    assign port_c_oe = {4{dir_c}};
    assign port_d_out = latch_d;
    assign port_d_oe = {4{dir_d}};
    assign standby = (state == nbd_pkg::ST_HALT) || (state == nbd_pkg::ST_STOP);
    assign osc_stopped = state == nbd_pkg::ST_STOP;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_settle_wait: assert property ($rose(rst_n) |->
        (state == nbd_pkg::ST_WAIT && pc == '0)[*8] ##1 state == nbd_pkg::ST_RUN)
        else $error("settle wait length wrong");
    a_skip_as_nop: assert property (state == nbd_pkg::ST_RUN && skip_next |->
        !mem_we ##1 pc == $past(pc) + 1'b1)
        else $error("skipped word not a no-op");
    a_jump_target: assert property (exec && is_jump |=> pc == $past(target))
        else $error("jump target not taken");
    a_call_saves: assert property (exec && is_call |=>
        return_address_stack == $past(pc) + 1'b1)
        else $error("return address not saved");
    a_ret_restores: assert property (exec && is_ret |=>
        pc == $past(return_address_stack) && skip_next == $past(imem_data[8]))
        else $error("return wrong");
    a_stop_ignored: assert property (exec && is_stop && port_b_in[1] |=>
        state == nbd_pkg::ST_RUN)
        else $error("stop entered with wake pin high");
    a_test_clears: assert property (exec && op == nbd_pkg::OP_SKT |=>
        !compare_flag && skip_next == $past(skt_hit))
        else $error("bit test wrong");
    a_rotate_right_via_carry_carry: assert property (exec && is_rotate_right_via_carry && raddr != nbd_pkg::A_PSW |=>
        carry_flag == $past(rval[0]))
        else $error("rotate carry wrong");
    a_pb3_zero: assert property (maddr == nbd_pkg::A_PORT_B |-> !mval[3])
        else $error("port B bit 3 not zero");

    c_call_ret: cover property (exec && is_call ##[1:20] exec && is_ret);
    c_halt_wake: cover property (state == nbd_pkg::ST_HALT ##1 state == nbd_pkg::ST_RUN);
    c_stop_wake: cover property (state == nbd_pkg::ST_STOP ##1 state == nbd_pkg::ST_WAIT);
    c_skip: cover property (next_skip);
endmodule : nbd_core

// *** include/nbd_pkg.sv ***
// Shared constants and types for the nibble core decoder
package nbd_pkg;
    localparam int PC_W = 11;
    localparam int SETTLE_CLKS = 8;
    // Operation codes, five bits
    localparam logic [4:0] OP_LD = 5'h08;
    localparam logic [4:0] OP_ST = 5'h18;
    localparam logic [4:0] OP_MOV = 5'h1D;
    localparam logic [4:0] OP_JMP = 5'h0C;
    localparam logic [4:0] OP_CALL = 5'h1C;
    localparam logic [4:0] OP_SKT = 5'h1E;
    localparam logic [4:0] OP_SKF = 5'h1F;
    localparam logic [4:0] OP_SKE = 5'h09;
    localparam logic [4:0] OP_SKIP_IF_NOT_EQUAL = 5'h0B;
    localparam logic [4:0] OP_SKIP_IF_NO_BORROW = 5'h19;
    localparam logic [4:0] OP_SKIP_IF_BORROW = 5'h1B;
    // Whole-word and upper-twelve-bit patterns of the special group
    localparam logic [15:0] W_RET = 16'h38E0;
    localparam logic [15:0] W_RETURN_THEN_SKIP = 16'h39E0;
    localparam logic [15:0] W_NOP = 16'h3CF0;
    localparam logic [11:0] W_ROTATE_RIGHT_VIA_CARRY = 12'h387;
    localparam logic [11:0] W_STOP = 12'h3AF;
    localparam logic [11:0] W_HALT = 12'h3BF;
    // ALU operations, equal to opcode bits 2..0
    localparam logic [2:0] ALU_ADD = 3'h0;
    localparam logic [2:0] ALU_SUB = 3'h1;
    localparam logic [2:0] ALU_ADD_PLUS_CARRY = 3'h2;
    localparam logic [2:0] ALU_SUBTRACT_MINUS_CARRY = 3'h3;
    localparam logic [2:0] ALU_AND = 3'h4;
    localparam logic [2:0] ALU_XOR = 3'h5;
    localparam logic [2:0] ALU_OR = 3'h6;
    localparam logic [2:0] ALU_NONE = 3'h7;
    localparam logic [4:0] BCD_MAX = 5'h09;
    localparam logic [3:0] BCD_ADJ = 4'h6;
    // Data memory map
    localparam logic [2:0] ROW_RAM = 3'h0;
    localparam logic [6:0] A_PORT_B = 7'h71;
    localparam logic [6:0] A_PORT_C = 7'h72;
    localparam logic [6:0] A_PORT_D = 7'h73;
    localparam logic [6:0] A_BCD = 7'h7E;
    localparam logic [6:0] A_PSW = 7'h7F;
    localparam int PSW_Z = 1;
    localparam int PSW_CY = 2;
    localparam int PSW_CMP = 3;
    localparam int BCD_BIT = 0;
    localparam int PB_WAKE = 1;
    localparam logic [3:0] STOP_INIT = 4'h0;
    localparam logic [0:0] SP_EMPTY = 1'h1;

    typedef struct packed {
        logic [4:0] opcode;
        logic [2:0] row_field;
        logic [3:0] column_field;
        logic [3:0] immediate_nibble;
    } nbd_instr_t;

    typedef enum logic [3:0] {
        ST_WAIT = 4'h1,
        ST_RUN = 4'h2,
        ST_HALT = 4'h4,
        ST_STOP = 4'h8
    } nbd_state_t;
endpackage : nbd_pkg

// *** verif/nbd_core_bench.sv ***
// Self-checking bench for the nibble core decoder
`timescale 1ns/10ps
module nbd_core_bench;
    logic ref_clk;
    logic rstn;
    logic [10:0] imem_addr;
    logic [15:0] imem_data;
    logic [2:0] port_b_in;
    logic [2:0] port_b_out;
    logic [2:0] port_b_oe;
    logic [3:0] port_c_in;
    logic [3:0] port_c_out;
    logic [3:0] port_c_oe;
    logic [3:0] port_d_in;
    logic [3:0] port_d_out;
    logic [3:0] port_d_oe;
    logic standby;
    logic osc_stopped;
    logic [15:0] rom [0:2047];
    logic [10:0] cp_pc [8];
    logic [7:0] cp_dc [8];
    int n_fail;
    int comparisons;

    nbd_core #(.PC_W(11)) i_nbd_core (
        .ref_clk(ref_clk), .rstn(rstn), .imem_addr(imem_addr), .imem_data(imem_data),
        .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
        .port_c_in(port_c_in), .port_c_out(port_c_out), .port_c_oe(port_c_oe),
        .port_d_in(port_d_in), .port_d_out(port_d_out), .port_d_oe(port_d_oe),
        .standby(standby), .osc_stopped(osc_stopped)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Program memory answers at the falling edge, settled before the next fetch
    always @(negedge ref_clk) imem_data <= rom[imem_addr];

    function automatic logic [15:0] w(input logic [4:0] op, input logic [6:0] m,
                                      input logic [3:0] n);
        return {op, m, n};
    endfunction : w

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // Bounded wait for the program counter to reach an address
    task automatic run_to(input logic [10:0] a);
        int k;
        k = 0;
        while (imem_addr !== a && k < 200)
        begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 200)
        begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, imem_addr, a);
            conclude();
        end
    endtask : run_to

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        foreach (rom[i]) rom[i] = nbd_pkg::W_NOP;
        rom[0] = w(nbd_pkg::OP_MOV, 7'h00, 4'h5);
        rom[1] = w(nbd_pkg::OP_MOV, 7'h01, 4'h9);
        rom[2] = w(5'h00, 7'h01, 4'h0);
        rom[3] = w(nbd_pkg::OP_ST, 7'h72, 4'h0);
        rom[4] = w(nbd_pkg::OP_MOV, 7'h02, 4'hf);
        rom[5] = w(5'h10, 7'h02, 4'h1);
        rom[6] = w(5'h12, 7'h02, 4'h3);
        rom[7] = w(nbd_pkg::OP_ST, 7'h72, 4'h2);
        rom[8] = w(5'h11, 7'h02, 4'h5);
        rom[9] = w(nbd_pkg::OP_LD, 7'h7f, 4'h3);
        rom[10] = w(nbd_pkg::OP_ST, 7'h73, 4'h3);
        rom[11] = w(5'h13, 7'h02, 4'h2);
        rom[12] = w(nbd_pkg::OP_ST, 7'h72, 4'h2);
        rom[13] = w(5'h16, 7'h02, 4'h3);
        rom[14] = w(5'h14, 7'h02, 4'h6);
        rom[15] = w(5'h15, 7'h02, 4'h5);
        rom[16] = w(5'h06, 7'h01, 4'h2);
        rom[17] = w(nbd_pkg::OP_ST, 7'h72, 4'h2);
        rom[18] = w(nbd_pkg::OP_MOV, 7'h7f, 4'h4);
        rom[19] = {nbd_pkg::W_ROTATE_RIGHT_VIA_CARRY, 4'h2};
        rom[20] = {nbd_pkg::W_ROTATE_RIGHT_VIA_CARRY, 4'h2};
        rom[21] = w(nbd_pkg::OP_ST, 7'h72, 4'h2);
        rom[23] = w(nbd_pkg::OP_SKE, 7'h01, 4'h9);
        rom[24] = w(nbd_pkg::OP_MOV, 7'h72, 4'h1);
        rom[25] = w(nbd_pkg::OP_SKIP_IF_NOT_EQUAL, 7'h01, 4'h9);
        rom[26] = w(nbd_pkg::OP_MOV, 7'h72, 4'h2);
        rom[27] = w(nbd_pkg::OP_SKIP_IF_NO_BORROW, 7'h01, 4'ha);
        rom[28] = w(nbd_pkg::OP_MOV, 7'h73, 4'h3);
        rom[29] = w(nbd_pkg::OP_SKIP_IF_BORROW, 7'h01, 4'ha);
        rom[30] = w(nbd_pkg::OP_MOV, 7'h73, 4'h5);
        rom[31] = w(nbd_pkg::OP_SKT, 7'h01, 4'h9);
        rom[32] = w(nbd_pkg::OP_MOV, 7'h72, 4'h7);
        rom[33] = w(nbd_pkg::OP_SKF, 7'h01, 4'h6);
        rom[34] = w(nbd_pkg::OP_MOV, 7'h72, 4'h8);
        rom[35] = w(nbd_pkg::OP_CALL, 7'h04, 4'h0);
        rom[36] = w(nbd_pkg::OP_MOV, 7'h72, 4'h9);
        rom[37] = w(nbd_pkg::OP_JMP, 7'h05, 4'h0);
        rom[64] = w(nbd_pkg::OP_MOV, 7'h73, 4'h6);
        rom[65] = nbd_pkg::W_RET;
        rom[80] = w(nbd_pkg::OP_CALL, 7'h06, 4'h0);
        rom[81] = w(nbd_pkg::OP_MOV, 7'h72, 4'ha);
        rom[82] = {nbd_pkg::W_HALT, 4'h1};
        rom[83] = {nbd_pkg::W_STOP, 4'h1};
        rom[85] = w(nbd_pkg::OP_SKF, 7'h71, 4'h2);
        rom[86] = w(nbd_pkg::OP_JMP, 7'h05, 4'h5);
        rom[87] = {nbd_pkg::W_STOP, 4'h1};
        rom[88] = w(nbd_pkg::OP_MOV, 7'h7e, 4'h1);
        rom[89] = w(nbd_pkg::OP_MOV, 7'h04, 4'h7);
        rom[90] = w(5'h10, 7'h04, 4'h5);
        rom[91] = w(nbd_pkg::OP_ST, 7'h72, 4'h4);
        rom[92] = w(nbd_pkg::OP_JMP, 7'h05, 4'hc);
        rom[96] = nbd_pkg::W_RETURN_THEN_SKIP;
        cp_pc = '{11'h004, 11'h008, 11'h00d, 11'h013, 11'h017, 11'h023, 11'h041, 11'h052};
        cp_dc = '{8'h0e, 8'h04, 8'h4c, 8'h4b, 8'h4e, 8'h32, 8'h62, 8'h69};
        n_fail = 0;
        comparisons = 0;
        rstn = 1'b0;
        port_b_in = 3'h0;
        port_c_in = 4'ha;
        port_d_in = 4'h5;
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk({5'h00, imem_addr}, 16'h0000);
        chk({12'h000, port_c_oe}, 16'h0000);
        run_to(11'h001);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            run_to(cp_pc[i]);
            chk({8'h00, port_d_out, port_c_out}, {8'h00, cp_dc[i]});
            $display("test checkpoint %0d done", i);
        end
        chk({12'h000, port_c_oe}, 16'h000f);
        chk({12'h000, port_d_oe}, 16'h000f);
        chk({13'h0000, port_b_oe}, 16'h0000);
        repeat (4) @(negedge ref_clk);
        chk({4'h0, standby, imem_addr}, 16'h0853);
        port_b_in = 3'h3;
        run_to(11'h055);
        repeat (3) @(negedge ref_clk);
        chk({4'h0, standby, imem_addr}, 16'h0056);
        port_b_in = 3'h0;
        run_to(11'h057);
        repeat (4) @(negedge ref_clk);
        chk({14'h0000, standby, osc_stopped}, 16'h0003);
        port_b_in = 3'h2;
        run_to(11'h05c);
        chk({12'h000, port_c_out}, 16'h0002);
        $display("test standby and decimal done");
        conclude();
    end
endmodule : nbd_core_bench
